// ==== asrc_pkg.sv ====
// shared constants and carrier types for the async sram host controller
package asrc_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 4;
  localparam int DEPTH = 16384;
  // bus timing in ns, cycle counts derived at 125 MHz
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_ACCESS_NS = 55;
  localparam int T_WRITE_PULSE_NS = 40;
  localparam int T_DATA_SETUP_NS = 25;
  localparam int T_ADDR_HOLD_NS = 5;
  localparam int T_OUT_OFF_NS = 25;
  localparam int ACC_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DS_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AH_CYC = (T_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_CYC = (T_OUT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 4'h0;

  typedef enum logic [2:0] {
    ASRC_IDLE, ASRC_RD_ACC, ASRC_WR_OFF, ASRC_WR_PULSE, ASRC_WR_HOLD
  } asrc_state_e;

  // request from the user side
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_s;

  // pins towards the memory, enables active low
  typedef struct packed {
    logic sel_n;
    logic out_en_n;
    logic wr_en_n;
    logic [ADDR_W-1:0] word_addr;
    logic [DATA_W-1:0] dq_o;
    logic [DATA_W-1:0] dq_oe_n;
  } asrc_pins_s;

  function automatic logic [CNT_W-1:0] asrc_cnt(input int n);
    asrc_cnt = (n < 1) ? 4'h1 : n[CNT_W-1:0];
  endfunction
endpackage

// ==== asrc_sync3.sv ====
// three-stage input synchroniser for the memory read data pins
`timescale 1ns/1ps
module asrc_sync3 #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // update only when second and third stage agree
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule

// ==== asrc_host.sv ====
// host controller driving an asynchronous 16k x 4 static memory
`timescale 1ns/1ps
module asrc_host #(
  parameter int ACC = asrc_pkg::ACC_CYC,
  parameter int WP = asrc_pkg::WP_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input asrc_pkg::asrc_req_s req,
  // read answer
  output logic rsp_valid,
  output logic [asrc_pkg::DATA_W-1:0] rsp_data,
  // memory pins
  output asrc_pkg::asrc_pins_s pins,
  input wire logic [asrc_pkg::DATA_W-1:0] dq_i
);
  import asrc_pkg::*;

  typedef struct packed {
    asrc_state_e st;
    logic [CNT_W-1:0] cnt;
    asrc_pins_s pins;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_data;
  } asrc_state_s;

  // edges from request taken to answer: access, three sync stages, output stage, answer flop
  localparam int RD_LAT = ACC + 5;

  asrc_state_s s_r;
  asrc_state_s s_nxt;
  logic [DATA_W-1:0] dq_sync;

  asrc_sync3 #(.W(DATA_W)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(dq_i),
    .dout(dq_sync)
  );

  assign req_ready = (s_r.st == ASRC_IDLE);
  assign pins = s_r.pins;
  assign rsp_valid = s_r.rsp_valid;
  assign rsp_data = s_r.rsp_data;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_valid = 1'b0;
    unique case (s_r.st)
      ASRC_IDLE: begin
        // idle: deselected, standby, our drivers off
        s_nxt.pins.sel_n = 1'b1;
        s_nxt.pins.out_en_n = 1'b1;
        s_nxt.pins.wr_en_n = 1'b1;
        s_nxt.pins.dq_oe_n = '1;
        if (req_valid) begin
          // address driven on the same edge that select falls, so access counts from that edge
          s_nxt.pins.word_addr = req.addr;
          s_nxt.pins.dq_o = req.wdata;
          s_nxt.pins.sel_n = 1'b0;
          if (req.wr) begin
            // fast write: output enable stays high so the memory never drives
            s_nxt.st = ASRC_WR_OFF;
            s_nxt.cnt = asrc_cnt(DS_CYC);
          end else begin
            // read: write enable high, select and output enable low
            s_nxt.pins.out_en_n = 1'b0;
            s_nxt.st = ASRC_RD_ACC;
            // synchroniser needs four edges after the pins settle, else stale data
            s_nxt.cnt = asrc_cnt(ACC) + asrc_cnt(4);
          end
        end
      end
      ASRC_RD_ACC: begin
        // wait access time plus synchroniser depth; no deselect pad needed
        if (s_r.cnt == 4'h1) begin
          s_nxt.rsp_valid = 1'b1;
          s_nxt.rsp_data = dq_sync;
          s_nxt.pins.sel_n = 1'b1;
          s_nxt.pins.out_en_n = 1'b1;
          s_nxt.st = ASRC_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      ASRC_WR_OFF: begin
        // our data drivers on only with output enable high
        s_nxt.pins.dq_oe_n = '0;
        s_nxt.pins.wr_en_n = 1'b0; // write begins as later falling edge
        s_nxt.st = ASRC_WR_PULSE;
        s_nxt.cnt = asrc_cnt(WP);
      end
      ASRC_WR_PULSE: begin
        // pulse covers data setup before the rising edge
        if (s_r.cnt == 4'h1) begin
          s_nxt.pins.wr_en_n = 1'b1;
          s_nxt.st = ASRC_WR_HOLD;
          s_nxt.cnt = asrc_cnt(AH_CYC);
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      ASRC_WR_HOLD: begin
        // data and address held after write enable rises
        if (s_r.cnt == 4'h1) begin
          s_nxt.pins.dq_oe_n = '1;
          s_nxt.pins.sel_n = 1'b1;
          s_nxt.st = ASRC_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      default: s_nxt.st = ASRC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.st <= ASRC_IDLE;
      s_r.cnt <= CNT_ZERO;
      s_r.pins <= {1'b1, 1'b1, 1'b1, ADDR_RST, DATA_RST, 4'hf};
      s_r.rsp_valid <= 1'b0;
      s_r.rsp_data <= DATA_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // our drivers never on while memory output enable is low
  chk_no_contention: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(s_r.pins.out_en_n == 1'b0 && s_r.pins.dq_oe_n != '1))
    else $error("host drives data while memory outputs enabled");
  chk_read_combo: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.st == ASRC_RD_ACC) |-> (!s_r.pins.sel_n && !s_r.pins.out_en_n && s_r.pins.wr_en_n))
    else $error("read without proper control levels");
  chk_read_latency: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req_valid && req_ready && !req.wr) |-> ##RD_LAT rsp_valid)
    else $error("read answer not at access time");
  chk_wr_data_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($rose(s_r.pins.wr_en_n)) |-> $stable(s_r.pins.dq_o) && s_r.pins.dq_oe_n == '0)
    else $error("write data not held at write enable rise");
  chk_wr_after_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(s_r.pins.wr_en_n) |-> !s_r.pins.sel_n && $past(!s_r.pins.sel_n))
    else $error("write enable fell before select");
  chk_fast_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s_r.pins.wr_en_n |-> s_r.pins.out_en_n)
    else $error("output enable low during write");
  chk_pulse_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(s_r.pins.wr_en_n) |-> !s_r.pins.wr_en_n [*5])
    else $error("write pulse too short");
  chk_idle_standby: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_r.st == ASRC_IDLE) |-> s_r.pins.sel_n && s_r.pins.wr_en_n)
    else $error("idle but memory selected");
  cov_read: cover property (@(posedge ref_clk) disable iff (!rst_n) rsp_valid);
  cov_write: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(s_r.pins.wr_en_n));
  cov_back: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(s_r.pins.wr_en_n) ##[1:20] rsp_valid);
endmodule

// ==== asrc_sram_model.sv ====
// behavioural model of the 16k x 4 asynchronous static memory
`timescale 1ns/1ps
module asrc_sram_model #(
  parameter int ACC_NS = 55
) (
  // controls, active low
  input wire logic sel_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  // address and data
  input wire logic [13:0] word_addr,
  input wire logic [3:0] din,
  output logic [3:0] q
);
  logic [3:0] mem [0:16383];
  logic ok;
  realtime stamp;
  initial begin
    q = 4'h0;
    ok = 1'b0;
    stamp = 0.0;
  end
  // any control or address move restarts access
  always @(sel_n or out_en_n or wr_en_n or word_addr) begin
    ok = 1'b0;
    stamp = $realtime;
  end
  // undriven pins toggle so a stale value never reads as good
  always #1 begin
    if ($realtime - stamp >= ACC_NS) ok = 1'b1;
    if (!sel_n && !out_en_n && wr_en_n && ok) q = mem[word_addr];
    else q = ~q;
  end
  always @(posedge wr_en_n) if (sel_n === 1'b0) mem[word_addr] = din;
  always @(posedge sel_n) if (wr_en_n === 1'b0) mem[word_addr] = din;
endmodule

// ==== tb_top.sv ====
// self-checking bench for the async sram host controller
`timescale 1ns/1ps
module tb_top;
  import asrc_pkg::*;
  logic ref_clk, rst_n, req_valid, req_ready, rsp_valid;
  asrc_req_s req;
  asrc_pins_s pins;
  logic [DATA_W-1:0] rsp_data, mem_q, bus;
  logic [DATA_W-1:0] shadow [0:DEPTH-1];
  logic [ADDR_W-1:0] ra;
  logic [ADDR_W-1:0] addr_q [$];
  int bad_count, num_checks, wp_len;

  asrc_host dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .pins(pins), .dq_i(bus));
  asrc_sram_model mem_u (.sel_n(pins.sel_n), .out_en_n(pins.out_en_n),
    .wr_en_n(pins.wr_en_n), .word_addr(pins.word_addr), .din(bus), .q(mem_q));
  // host bit where its driver is on, else the memory's
  assign bus = (pins.dq_o & ~pins.dq_oe_n) | (mem_q & pins.dq_oe_n);

  always #4 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [3:0] exp_rd(input logic [13:0] a);
    return shadow[a];
  endfunction

  task automatic xfer(input logic w, input logic [13:0] a, input logic [3:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{wr: w, addr: a, wdata: d};
    @(posedge ref_clk);
    while (req_ready !== 1'b1 && n < 30) begin
      @(posedge ref_clk);
      n++;
    end
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (n < 30 && (w ? req_ready : rsp_valid) !== 1'b1);
    if (n >= 30) begin
      bad_count++;
      complete_run();
    end
    chk("turnaround", w ? 16'(WP_CYC + 3) : 16'(ACC_CYC + 5), 16'(n));
    if (w) shadow[a] = d;
    else chk("read data", 16'(exp_rd(a)), 16'(rsp_data));
    @(posedge ref_clk);
  endtask

  // strobe only inside select, memory outputs parked, host drivers on
  always @(negedge ref_clk) begin
    if (rst_n && pins.wr_en_n === 1'b0) begin
      wp_len++;
      chk("write pins", 16'h0000, 16'({pins.sel_n, ~pins.out_en_n, pins.dq_oe_n}));
    end else if (rst_n && wp_len != 0) begin
      chk("write pulse", 16'(WP_CYC), 16'(wp_len));
      wp_len = 0;
    end
    if (rst_n && pins.out_en_n === 1'b0) chk("read pins", 16'h001f, 16'({pins.wr_en_n, pins.dq_oe_n}));
  end

  initial begin
    #800000;
    bad_count++;
    complete_run();
  end

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    bad_count = 0;
    num_checks = 0;
    wp_len = 0;
    void'($urandom(32'h638d));
    repeat (16) @(posedge ref_clk);
    chk("reset pins", 16'h00ff, 16'({pins.sel_n, pins.out_en_n, pins.wr_en_n, pins.dq_oe_n, req_ready}));
    rst_n <= 1'b1;
    @(posedge ref_clk);
    xfer(1'b1, 14'h0000, 4'ha);
    xfer(1'b1, 14'h3fff, 4'h5);
    xfer(1'b0, 14'h0000, 4'h0);
    xfer(1'b0, 14'h3fff, 4'h0);
    xfer(1'b1, 14'h3fff, 4'hc);
    xfer(1'b0, 14'h3fff, 4'h0);
    $display("test corners done");
    for (int i = 0; i < 40; i++) begin
      ra = 14'($urandom);
      xfer(1'b1, ra, 4'($urandom));
      addr_q.push_back(ra);
    end
    foreach (addr_q[i]) xfer(1'b0, addr_q[i], 4'h0);
    $display("test random done");
    complete_run();
  end
endmodule
